// >>> inc/dca_pkg.sv
package dca_pkg;
	// register indices; byte address is four times the index
	localparam logic [3:0] IDX_LEFT_LOW = 4'h0;
	localparam logic [3:0] IDX_LEFT_HIGH = 4'h1;
	localparam logic [3:0] IDX_RIGHT_LOW = 4'h2;
	localparam logic [3:0] IDX_RIGHT_HIGH = 4'h3;
	localparam logic [3:0] IDX_GAIN_MODE = 4'h4;
	localparam logic [3:0] IDX_PATH_MODE = 4'h8;
	localparam logic [3:0] IDX_STATUS = 4'hC;
	// field positions
	localparam int UPD_BIT = 5;
	localparam int RAMP_BIT = 0;
	localparam int CLIP_BIT = 1;
	localparam int FOLLOW_BIT = 2;
	localparam int BSG_BIT = 6;
	localparam int STAT_RIGHT_LSB = 16;
	localparam int STAT_PEND_BIT = 31;
	// reset values and codes
	localparam logic [4:0] HALF_RST = 5'h00;
	localparam logic [9:0] CODE_RST = 10'h000;
	localparam logic [9:0] CODE_MUTE = 10'h3FF;
	localparam logic CTRL_RST = 1'b0;
	// ramp timing: 1.000 ms/dB at 32 kHz, same sample count for all rates
	localparam int RAMP_US_PER_DB = 1000;
	localparam int RAMP_FS_KHZ = 32;
	localparam int STEPS_PER_DB = 8;
	localparam int RAMP_SAMPLES_PER_STEP = RAMP_US_PER_DB * RAMP_FS_KHZ / 1000 / STEPS_PER_DB;
	// gain in q16; per-bit factors for 0.125 .. 64 dB, last entry is 2 dB cut
	localparam int SAMPLE_W = 24;
	localparam int CALC_STEPS = 11;
	localparam logic [16:0] GAIN_ONE = 17'h1_0000;
	localparam logic [15:0] ATT_FACTOR [CALC_STEPS] = '{
		16'hFC58, 16'hF8BD, 16'hF1AE, 16'hE429, 16'hCB59, 16'hA186,
		16'h65EA, 16'h2893, 16'h066E, 16'h0029, 16'hCB59};
	typedef struct packed {
		logic signed [SAMPLE_W-1:0] left;
		logic signed [SAMPLE_W-1:0] right;
	} dca_pair_type;
endpackage : dca_pkg

// >>> rtl/dca_attenuator.sv
// Operation
// (R1) attenuate 0 dB down in 0.125 dB steps
// (R2) code joins low and high five-bit halves
// (R3) write without update only fills pre-latch
// (R4) update write applies all halves next sample
// (R5) update bit never stored, reads zero
// (R6) linear code decode, 3FF mutes channel
// (R7) reset gives zero codes, update clear
// (R8) attenuation applied digitally before filtering
// (R9) follow mode uses left code both channels
// (R10) right codes preserved, return when cleared
// (R11) no ramp: jump to new gain
// (R12) ramp at documented speed per dB
// (R13) anticlip adds fixed 2 dB cut
// (R14) gain select bit drives bitstream path gain
// (R15) ramp one step per tick, redirectable
// (R16) host writes halves, update on last
//
// The APB slave port was decided locally.
`timescale 1ns/1ps
module dca_attenuator
	import dca_pkg::*;
(
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// sample stream in
	input wire logic in_valid,
	output logic in_ready,
	input wire dca_pair_type in_data,
	// sample stream out, ahead of filtering
	output logic out_valid,
	output dca_pair_type out_data,
	// path gain select
	output logic bitstream_path_gain
);

	////////////////////////////////////////////////////////////////////////
	function automatic logic addr_ok(input logic [7:0] a);
		logic [3:0] i;
		i = a[5:2];
		addr_ok = (a[7:6] == 2'b00) && (a[1:0] == 2'b00) && ((i <= IDX_GAIN_MODE) ||
			(i == IDX_PATH_MODE) || (i == IDX_STATUS));
	endfunction : addr_ok

	function automatic logic [9:0] step_to(input logic [9:0] c, input logic [9:0] t);
		step_to = (c < t) ? c + 10'h001 : ((c > t) ? c - 10'h001 : c);
	endfunction : step_to

	logic [4:0] pre_reg [4];
	logic [9:0] tgt_l_reg, tgt_r_reg;
	logic [9:0] cur_reg [2];
	logic pend_reg, ramp_reg, clip_reg, follow_reg, bsg_reg;
	logic [1:0] rdiv_reg;
	logic busy_reg, out_valid_reg;
	logic [3:0] cnt_reg;
	logic [16:0] acc_reg [2];
	logic signed [SAMPLE_W-1:0] res_reg [2];
	dca_pair_type smp_reg;
	logic [31:0] prdata_reg;
	logic pslverr_reg;
	logic [3:0] idx;
	logic wr, wr_atten, set_pend, fire, take, step_ok;
	logic [9:0] new_l, new_r, eff_r;

	////////////////////////////////////////////////////////////////////////
	// bus decode
	assign idx = paddr[5:2];
	assign wr = psel & penable & pwrite & addr_ok(paddr);
	assign wr_atten = wr & (idx <= IDX_RIGHT_HIGH);
	assign set_pend = wr_atten & pwdata[UPD_BIT]; // R4
	assign pready = 1'b1;
	assign prdata = prdata_reg;
	assign pslverr = pslverr_reg;

	// read data and error captured in setup phase
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_reg <= 32'h0000_0000;
			pslverr_reg <= 1'b0;
		end else if (psel && !penable) begin
			pslverr_reg <= ~addr_ok(paddr);
			prdata_reg <= 32'h0000_0000;
			if (addr_ok(paddr) && !pwrite) begin
				case (idx)
					IDX_LEFT_LOW, IDX_LEFT_HIGH, IDX_RIGHT_LOW, IDX_RIGHT_HIGH: begin
						prdata_reg[4:0] <= pre_reg[idx[1:0]]; // R5
					end
					IDX_GAIN_MODE: begin
						prdata_reg[RAMP_BIT] <= ramp_reg;
						prdata_reg[CLIP_BIT] <= clip_reg;
						prdata_reg[FOLLOW_BIT] <= follow_reg;
					end
					IDX_PATH_MODE: begin
						prdata_reg[BSG_BIT] <= bsg_reg;
					end
					IDX_STATUS: begin
						prdata_reg[9:0] <= cur_reg[0];
						prdata_reg[STAT_RIGHT_LSB +: 10] <= cur_reg[1];
						prdata_reg[STAT_PEND_BIT] <= pend_reg;
					end
					default: begin
						prdata_reg <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// pre-latch halves, one per register
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_pre
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					pre_reg[g] <= HALF_RST; // R7
				end else if (wr_atten && idx[1:0] == 2'(g)) begin
					pre_reg[g] <= pwdata[4:0]; // R3
				end
			end
		end
	endgenerate

	// mode control bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ramp_reg <= CTRL_RST;
			clip_reg <= CTRL_RST;
			follow_reg <= CTRL_RST;
			bsg_reg <= CTRL_RST;
		end else if (wr && idx == IDX_GAIN_MODE) begin
			ramp_reg <= pwdata[RAMP_BIT];
			clip_reg <= pwdata[CLIP_BIT];
			follow_reg <= pwdata[FOLLOW_BIT];
		end else if (wr && idx == IDX_PATH_MODE) begin
			bsg_reg <= pwdata[BSG_BIT]; // R14
		end
	end
	assign bitstream_path_gain = bsg_reg;

	////////////////////////////////////////////////////////////////////////
	// update trigger; a new update beats a clear in the same cycle
	assign fire = in_valid & in_ready;
	assign take = fire & pend_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pend_reg <= 1'b0;
		end else begin
			pend_reg <= set_pend | (pend_reg & ~take); // R4 R5
		end
	end

	// applied targets, joined from halves
	assign new_l = take ? {pre_reg[1], pre_reg[0]} : tgt_l_reg; // R2
	assign new_r = take ? {pre_reg[3], pre_reg[2]} : tgt_r_reg; // R2
	assign eff_r = follow_reg ? new_l : new_r; // R9 R10
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tgt_l_reg <= CODE_RST;
			tgt_r_reg <= CODE_RST;
		end else if (take) begin
			tgt_l_reg <= new_l; // R4
			tgt_r_reg <= new_r; // R10
		end
	end

	// ramp divider, samples per 0.125 dB step
	assign step_ok = (rdiv_reg == 2'(RAMP_SAMPLES_PER_STEP - 1)); // R12
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdiv_reg <= 2'b00;
		end else if (fire) begin
			rdiv_reg <= ramp_reg ? rdiv_reg + 2'b01 : 2'b00;
		end
	end

	// present codes, moved at each accepted sample, or at every fourth one while ramping
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cur_reg[0] <= CODE_RST; // R7
			cur_reg[1] <= CODE_RST;
		end else if (fire) begin
			if (!ramp_reg) begin
				cur_reg[0] <= new_l; // R11
				cur_reg[1] <= eff_r; // R9
			end else if (step_ok) begin
				cur_reg[0] <= step_to(cur_reg[0], new_l); // R15
				cur_reg[1] <= step_to(cur_reg[1], eff_r); // R15
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// sample sequencer: gain built bit by bit, then multiply
	assign in_ready = ~busy_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_reg <= 1'b0;
			cnt_reg <= 4'h0;
			out_valid_reg <= 1'b0;
			smp_reg <= '0;
		end else begin
			out_valid_reg <= 1'b0;
			if (fire) begin
				busy_reg <= 1'b1;
				cnt_reg <= 4'h0;
				smp_reg <= in_data;
			end else if (busy_reg && cnt_reg == 4'(CALC_STEPS)) begin
				busy_reg <= 1'b0;
				out_valid_reg <= 1'b1;
			end else if (busy_reg) begin
				cnt_reg <= cnt_reg + 4'h1;
			end
		end
	end
	assign out_valid = out_valid_reg;

	// per channel gain and product
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			logic bit_on;
			logic [32:0] prod;
			logic signed [SAMPLE_W-1:0] smp;
			logic signed [SAMPLE_W+17:0] scaled;
			assign bit_on = (cnt_reg < 4'hA) ? cur_reg[g][cnt_reg] : clip_reg; // R1 R6 R13
			assign prod = acc_reg[g] * ATT_FACTOR[cnt_reg];
			assign smp = (g == 0) ? smp_reg.left : smp_reg.right;
			assign scaled = smp * $signed({1'b0, acc_reg[g]}); // R8
			always_ff @(posedge pclk or negedge presetn) begin
				if (!presetn) begin
					acc_reg[g] <= GAIN_ONE;
					res_reg[g] <= '0;
				end else if (fire) begin
					acc_reg[g] <= GAIN_ONE;
				end else if (busy_reg && cnt_reg < 4'(CALC_STEPS)) begin
					if (bit_on) begin
						acc_reg[g] <= prod[32:16]; // R1
					end
				end else if (busy_reg) begin
					res_reg[g] <= (cur_reg[g] == CODE_MUTE) ? '0 : scaled[SAMPLE_W+15:16]; // R6
				end
			end
		end
	endgenerate
	assign out_data = '{left: res_reg[0], right: res_reg[1]};

	////////////////////////////////////////////////////////////////////////
	// checks
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic seen_take_reg;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			seen_take_reg <= 1'b0;
		end else if (take) begin
			seen_take_reg <= 1'b1;
		end
	end

	property p_reset_zero;
		!seen_take_reg |-> (tgt_l_reg == CODE_RST) && (tgt_r_reg == CODE_RST);
	endproperty
	a_reset_zero: assert property (p_reset_zero) else $error("target not zero before update"); // R7
	property p_prelatch_only;
		(wr_atten && !pwdata[UPD_BIT] && !pend_reg) |=> $stable(tgt_l_reg) && $stable(tgt_r_reg);
	endproperty
	a_prelatch_only: assert property (p_prelatch_only) else $error("plain write moved target"); // R3
	property p_update_apply;
		take |=> tgt_l_reg == {$past(pre_reg[1]), $past(pre_reg[0])};
	endproperty
	a_update_apply: assert property (p_update_apply) else $error("update not applied"); // R4
	property p_update_reads_zero;
		(psel && !penable && !pwrite && paddr == 8'h00) |=> prdata[UPD_BIT] == 1'b0;
	endproperty
	a_update_reads_zero: assert property (p_update_reads_zero) else $error("update bit kept"); // R5
	property p_mute;
		out_valid && cur_reg[0] == CODE_MUTE |-> out_data.left == '0;
	endproperty
	a_mute: assert property (p_mute) else $error("mute code passed signal"); // R6
	property p_unity;
		out_valid && cur_reg[0] == CODE_RST && !clip_reg |-> out_data.left == smp_reg.left;
	endproperty
	a_unity: assert property (p_unity) else $error("0 dB not transparent"); // R1
	property p_follow;
		fire && follow_reg && !ramp_reg |=> cur_reg[1] == cur_reg[0];
	endproperty
	a_follow: assert property (p_follow) else $error("right not following left"); // R9
	property p_single_step;
		fire && !ramp_reg |=> cur_reg[0] == tgt_l_reg;
	endproperty
	a_single_step: assert property (p_single_step) else $error("no jump to target"); // R11
	property p_ramp_rate;
		fire && ramp_reg && !step_ok |=> $stable(cur_reg[0]) && $stable(cur_reg[1]);
	endproperty
	a_ramp_rate: assert property (p_ramp_rate) else $error("ramp too fast"); // R12
	property p_ramp_step;
		fire && ramp_reg |=> (cur_reg[0] - $past(cur_reg[0]) <= 10'h001) ||
			($past(cur_reg[0]) - cur_reg[0] <= 10'h001);
	endproperty
	a_ramp_step: assert property (p_ramp_step) else $error("ramp step above one code"); // R15
	property p_anticlip;
		busy_reg && cnt_reg == 4'(CALC_STEPS) && clip_reg && cur_reg[0] == CODE_RST
			|-> acc_reg[0] == {1'b0, ATT_FACTOR[CALC_STEPS-1]};
	endproperty
	a_anticlip: assert property (p_anticlip) else $error("anticlip cut wrong"); // R13
	property p_path_gain;
		wr && idx == IDX_PATH_MODE |=> bitstream_path_gain == $past(pwdata[BSG_BIT]);
	endproperty
	a_path_gain: assert property (p_path_gain) else $error("path gain not taken"); // R14
	// result registered at the twelfth edge, so seen high at the thirteenth
	property p_latency;
		fire |-> ##13 out_valid;
	endproperty
	a_latency: assert property (p_latency) else $error("output latency wrong"); // R8

	c_ramp: cover property (fire && ramp_reg && step_ok && cur_reg[0] != tgt_l_reg);
	c_mute: cover property (out_valid && cur_reg[0] == CODE_MUTE);
	c_follow: cover property (fire && follow_reg && tgt_r_reg != tgt_l_reg);
	c_update: cover property (take);

endmodule : dca_attenuator

// >>> verification/dca_host_model.sv
`timescale 1ns/1ps
module dca_host_model
	import dca_pkg::*;
(
	// clock
	input wire logic pclk,
	// apb master side
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// idle bus from time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end
	////////////////////////////////////////////////////////////////
	// one transfer, held until pready is sampled high or 20 edges have passed
	task automatic xfer(input logic wr, input logic [3:0] idx, input logic [31:0] wd,
		output logic [31:0] rd, output logic err);
		int n;
		err = 1'bx;
		rd = 32'h0000_0000;
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= {2'b00, idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge pclk);
			n++;
		end while (pready !== 1'b1 && n < 20);
		if (pready === 1'b1) begin
			rd = prdata;
			err = pslverr;
		end
		// released data never shows the last value
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~wd;
	endtask : xfer
endmodule : dca_host_model

// >>> verification/dca_attenuator_bench.sv
`timescale 1ns/1ps
module dca_attenuator_bench
	import dca_pkg::*;
;
	localparam logic [23:0] LS = 24'h40_0000;
	localparam logic [23:0] RS = 24'hF0_0000;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic in_valid, in_ready, out_valid, bitstream_path_gain;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	dca_pair_type in_data, out_data;
	int bad_count = 0;
	int cmp_count = 0;
	logic [31:0] st;
	////////////////////////////////////////////////////////////////
	// design and host
	dca_attenuator u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .in_valid(in_valid), .in_ready(in_ready), .in_data(in_data),
		.out_valid(out_valid), .out_data(out_data), .bitstream_path_gain(bitstream_path_gain));
	dca_host_model u_host (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
	initial begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end
	////////////////////////////////////////////////////////////////
	// helpers
	task automatic give_verdict();
		if (bad_count == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [47:0] seen, input logic [47:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	function automatic logic [23:0] scl(input logic [23:0] s, input logic [16:0] f);
		logic signed [41:0] p;
		p = $signed(s) * $signed({1'b0, f});
		return p[39:16];
	endfunction : scl
	task automatic rd(input logic [3:0] idx, output logic [31:0] d);
		logic e;
		u_host.xfer(1'b0, idx, 32'h0000_0000, d, e);
		chk(e, 1'b0);
		// bus timeout ends the run
		if (e === 1'bx) begin
			give_verdict();
		end
	endtask : rd
	task automatic wr(input logic [3:0] idx, input logic [31:0] d);
		logic e;
		logic [31:0] r;
		u_host.xfer(1'b1, idx, d, r, e);
		chk(e, 1'b0);
		// bus timeout ends the run
		if (e === 1'bx) begin
			give_verdict();
		end
	endtask : wr
	// one sample through, compared against the two expected gains when cmp is set
	task automatic send(input logic [16:0] fl, input logic [16:0] fr, input logic cmp);
		int n;
		logic t;
		n = 0;
		// launch only just after a rising edge
		@(posedge pclk);
		in_data <= {LS, RS};
		in_valid <= 1'b1;
		do begin
			@(negedge pclk);
			t = in_ready;
			@(posedge pclk);
			n++;
		end while (t !== 1'b1 && n < 40);
		in_valid <= 1'b0;
		in_data <= ~{LS, RS};
		n = 0;
		do begin
			@(negedge pclk);
			n++;
		end while (out_valid !== 1'b1 && n < 40);
		if (t !== 1'b1 || out_valid !== 1'b1) begin
			bad_count++;
			give_verdict();
		end else if (cmp) begin
			chk(out_data, {scl(LS, fl), scl(RS, fr)});
		end
	endtask : send
	////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_reset();
		logic [3:0] idx [7] = '{IDX_LEFT_LOW, IDX_LEFT_HIGH, IDX_RIGHT_LOW, IDX_RIGHT_HIGH,
			IDX_GAIN_MODE, IDX_PATH_MODE, IDX_STATUS};
		foreach (idx[i]) begin
			rd(idx[i], st);
			chk(st, 32'h0000_0000);
		end
		chk(bitstream_path_gain, 1'b0);
		send(GAIN_ONE, GAIN_ONE, 1'b1);
	endtask : t_reset
	task automatic t_prelatch();
		wr(IDX_LEFT_LOW, 32'h0000_0008);
		send(GAIN_ONE, GAIN_ONE, 1'b1);
		wr(IDX_RIGHT_HIGH, 32'h0000_0021);
		rd(IDX_RIGHT_HIGH, st);
		chk(st, 32'h0000_0001);
		rd(IDX_STATUS, st);
		chk(st, 32'h8000_0000);
		send({1'b0, ATT_FACTOR[3]}, {1'b0, ATT_FACTOR[5]}, 1'b1);
		rd(IDX_STATUS, st);
		chk(st, 32'h0020_0008);
	endtask : t_prelatch
	task automatic t_follow();
		wr(IDX_GAIN_MODE, 32'h0000_0004);
		send({1'b0, ATT_FACTOR[3]}, {1'b0, ATT_FACTOR[3]}, 1'b1);
		wr(IDX_GAIN_MODE, 32'h0000_0000);
		send({1'b0, ATT_FACTOR[3]}, {1'b0, ATT_FACTOR[5]}, 1'b1);
	endtask : t_follow
	task automatic t_mute_clip();
		wr(IDX_LEFT_HIGH, 32'h0000_001F);
		wr(IDX_LEFT_LOW, 32'h0000_003F);
		send(17'h0_0000, {1'b0, ATT_FACTOR[5]}, 1'b1);
		rd(IDX_STATUS, st);
		chk(st, 32'h0020_03FF);
		// halves first, update on the last half write, then anticlip on
		wr(IDX_LEFT_LOW, 32'h0000_0000);
		wr(IDX_LEFT_HIGH, 32'h0000_0000);
		wr(IDX_RIGHT_HIGH, 32'h0000_0020);
		wr(IDX_GAIN_MODE, 32'h0000_0002);
		send({1'b0, ATT_FACTOR[10]}, {1'b0, ATT_FACTOR[10]}, 1'b1);
	endtask : t_mute_clip
	task automatic t_ramp();
		wr(IDX_GAIN_MODE, 32'h0000_0001);
		wr(IDX_LEFT_LOW, 32'h0000_0024);
		send(GAIN_ONE, GAIN_ONE, 1'b0);
		rd(IDX_STATUS, st);
		chk(st[9:0] < 10'h004, 1'b1);
		// one code step every fourth sample: two steps after eight samples
		repeat (7) begin
			send(GAIN_ONE, GAIN_ONE, 1'b0);
		end
		rd(IDX_STATUS, st);
		chk(st, 32'h0000_0002);
		repeat (13) begin
			send(GAIN_ONE, GAIN_ONE, 1'b0);
		end
		rd(IDX_STATUS, st);
		chk(st, 32'h0000_0004);
	endtask : t_ramp
	task automatic t_path();
		logic e;
		wr(IDX_PATH_MODE, 32'h0000_0040);
		// let the write edge settle before looking at the pin
		@(negedge pclk);
		chk(bitstream_path_gain, 1'b1);
		u_host.xfer(1'b1, 4'h5, 32'h0000_0001, st, e);
		chk(e, 1'b1);
		if (e === 1'bx) begin
			give_verdict();
		end
	endtask : t_path
	////////////////////////////////////////////////////////////////
	// main sequence
	initial begin
		presetn = 1'b0;
		in_valid = 1'b0;
		in_data = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		t_reset();
		t_prelatch();
		t_follow();
		t_mute_clip();
		t_ramp();
		t_path();
		give_verdict();
	end
endmodule : dca_attenuator_bench
